// File: hdl/pi_core.sv
/*
  One sample of the actual-loop PI controller, computed combinationally and
  registered by the caller. Assumes inputs stable for the sample cycle.
*/
`timescale 1ns/10ps
module pi_core #(
  parameter int W = 24
) (
  input wire logic signed [W-1:0] err,
  input wire logic [15:0] kp_pct,
  input wire logic [15:0] ti_ms,
  input wire logic signed [W+15:0] integ_in,
  input wire logic hold_integ,
  output logic signed [W+15:0] integ_out,
  output logic signed [W+15:0] torque
);

  // ----------------------------------------------------------------------
  // Integral accumulates err * Ts / Ti; Ts = 0.1 ms so Ts/Ti = 1/(10*Ti_ms)
  // ----------------------------------------------------------------------
  logic signed [W+15:0] step;
  logic signed [W+15:0] err_q8;
  logic signed [W+15:0] ti_den;
  logic signed [W+31:0] prod;
  logic signed [W+15:0] sum;
  always_comb
  begin
    err_q8 = (W+16)'(err) <<< 8;
    // Divisor sized wide so 10 * 20000 ms cannot wrap
    ti_den = signed'((W+16)'(ti_ms) * (W+16)'(10));
    step = '0;
    // Ti of zero disables the integral rather than dividing by zero
    if (!hold_integ && ti_ms != 16'h0000)
    begin
      step = err_q8 / ti_den;
    end
    integ_out = integ_in + step;
    sum = err_q8 + integ_out;
    // Gain in percent of the 200 rad/s base response, scaled back by 2^8
    prod = (W+32)'(sum * signed'({1'b0, kp_pct}));
    torque = (W+16)'(prod / (W+32)'(25600));
  end

endmodule : pi_core

// File: hdl/speed_loop_pi_controller.sv
/*
  Speed-loop controller with ideal model, PI actual loop, position and speed
  feed-forward and P/PI select. Registers reached over a plain port with
  read data one cycle after the read strobe. Select input is an async pin.
*/
// Function
// R1: Proportional gain accepted 0..1000 %, reset 100 % small or 15 % large units.
// R2: Gain 100 % equals 200 rad/s speed response.
// R3: Integral time accepted 0..20 s, reset 0.2 s small or 0.333 s large.
// R4: Gain and integral time writable only while visibility setting equals zero.
// R5: Select input inactive gives proportional plus integral control.
// R6: Select input active gives proportional-only control, integral omitted.
// R7: Under position control the select input is ignored; PI always.
// R8: Operator routes a terminal to the select input with function code 44.
// R9: Ideal model derived from load inertia, its gain independent of actual loop.
// R10: Actual loop is a proportional-integral controller.
// R11: Actual loop torque drives motor to follow model speed.
// R12: Position feed-forward adds precomputed speed command.
// R13: Speed feed-forward adds precomputed acceleration torque command.
// R14: Fixed sample period; integral sums error over Ti; gain scales sum.
`timescale 1ns/10ps
module speed_loop_pi_controller #(
  parameter int W = 24,
  parameter bit LARGE_UNIT = 1'b0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic p_pi_select_input,
  input wire logic signed [W-1:0] speed_cmd,
  input wire logic signed [W-1:0] pos_err,
  input wire logic signed [W-1:0] speed_fb,
  output logic signed [W-1:0] torque_cmd,
  output logic sample_valid
);

  initial
  begin
    if (W < 8 || W > 32)
    begin
      $error("W must lie in 8..32");
    end
  end

  // ----------------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------------
  logic [15:0] kp_q;
  logic [15:0] ti_q;
  logic [15:0] jl_q;
  logic [15:0] ffg_q;
  logic [1:0] vis_q;
  logic pos_ff_q;
  logic spd_ff_q;
  logic pos_mode_q;
  logic en_q;
  logic range_err_q;
  logic [31:0] rdata_q;

  function automatic logic in_range(input logic [31:0] v, input logic [15:0] mx);
    in_range = (v <= {16'h0000, mx});
  endfunction : in_range

  wire unlocked = (vis_q == 2'h0);

  // Gain and integral time writes, gated by the visibility setting
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      kp_q <= LARGE_UNIT ? speed_loop_pkg::KP_INIT_LARGE_PCT : speed_loop_pkg::KP_INIT_SMALL_PCT; // [R1]
      ti_q <= LARGE_UNIT ? speed_loop_pkg::TI_INIT_LARGE_MS : speed_loop_pkg::TI_INIT_SMALL_MS; // [R3]
    end
    else if (wr && unlocked) // [R4]
    begin
      if (addr == speed_loop_pkg::REG_KP && in_range(wdata, speed_loop_pkg::KP_MAX_PCT))
      begin
        kp_q <= wdata[15:0]; // [R1]
      end
      if (addr == speed_loop_pkg::REG_TI && in_range(wdata, speed_loop_pkg::TI_MAX_MS))
      begin
        ti_q <= wdata[15:0]; // [R3]
      end
    end
  end

  // Sticky flag for refused out-of-range or locked writes; set wins over clear
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      range_err_q <= 1'b0;
    end
    else if (wr && (addr == speed_loop_pkg::REG_KP || addr == speed_loop_pkg::REG_TI)
             && (!unlocked
                 || (addr == speed_loop_pkg::REG_KP && !in_range(wdata, speed_loop_pkg::KP_MAX_PCT))
                 || (addr == speed_loop_pkg::REG_TI && !in_range(wdata, speed_loop_pkg::TI_MAX_MS))))
    begin
      range_err_q <= 1'b1;
    end
    else if (wr && addr == speed_loop_pkg::REG_STATUS && wdata[speed_loop_pkg::STAT_RANGE_ERR])
    begin
      range_err_q <= 1'b0;
    end
  end

  // Other configuration, always writable
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      vis_q <= 2'h0;
      pos_ff_q <= 1'b0;
      spd_ff_q <= 1'b0;
      pos_mode_q <= 1'b0;
      en_q <= 1'b0;
      jl_q <= speed_loop_pkg::JL_INIT;
      ffg_q <= 16'h0000;
    end
    else if (wr)
    begin
      if (addr == speed_loop_pkg::REG_CTRL)
      begin
        vis_q <= wdata[speed_loop_pkg::CTRL_VIS_LO +: 2];
        pos_ff_q <= wdata[speed_loop_pkg::CTRL_POS_FF];
        spd_ff_q <= wdata[speed_loop_pkg::CTRL_SPD_FF];
        pos_mode_q <= wdata[speed_loop_pkg::CTRL_POS_MODE];
        en_q <= wdata[speed_loop_pkg::CTRL_ENABLE];
      end
      if (addr == speed_loop_pkg::REG_JL)
      begin
        jl_q <= wdata[15:0];
      end
      if (addr == speed_loop_pkg::REG_FF_GAIN)
      begin
        ffg_q <= wdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Select input synchroniser and sample divider
  // ----------------------------------------------------------------------
  logic sel_meta_q;
  logic sel_q;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sel_meta_q <= 1'b0;
      sel_q <= 1'b0;
    end
    else
    begin
      sel_meta_q <= p_pi_select_input;
      sel_q <= sel_meta_q;
    end
  end

  // Position control forces PI whatever the pin says
  wire p_only = sel_q && !pos_mode_q; // [R5] [R6] [R7]

  logic [15:0] div_q;
  logic tick;
  assign tick = (div_q == 16'(speed_loop_pkg::SAMPLE_CYCLES - 1));
  // Fixed sample period as a one-cycle enable
  always_ff @(posedge mclk)
  begin
    if (rst || tick)
    begin
      div_q <= 16'h0000; // [R14]
    end
    else
    begin
      div_q <= div_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Ideal model: first-order follower of the command, rate set by inertia
  // ----------------------------------------------------------------------
  logic signed [W-1:0] model_q;
  logic signed [W-1:0] cmd_eff;
  logic signed [W+16:0] model_step;
  always_comb
  begin
    // Position feed-forward adds the speed needed to close the position error
    cmd_eff = speed_cmd + (pos_ff_q ? (pos_err >>> 2) : '0); // [R12]
    // Heavier load slows the model: step = diff * 2^8 / (2^8 + Jl) / 16
    model_step = (W+17)'(signed'({{17{cmd_eff[W-1]}}, cmd_eff} - {{17{model_q[W-1]}}, model_q}) <<< 4)
                 / signed'({2'b00, 16'h0100} + {2'b00, jl_q}); // [R9]
  end

  always_ff @(posedge mclk)
  begin
    if (rst || !en_q)
    begin
      model_q <= '0;
    end
    else if (tick)
    begin
      model_q <= model_q + W'(model_step); // [R9]
    end
  end

  // ----------------------------------------------------------------------
  // Actual loop
  // ----------------------------------------------------------------------
  logic signed [W+15:0] integ_q;
  logic signed [W+15:0] integ_next;
  logic signed [W+15:0] pi_torque;
  logic signed [W-1:0] err;
  assign err = model_q - speed_fb; // [R11]

  pi_core #(
    .W(W)
  ) u_pi (
    .err(err),
    .kp_pct(kp_q),
    .ti_ms(ti_q),
    .integ_in(integ_q),
    .hold_integ(p_only),
    .integ_out(integ_next),
    .torque(pi_torque)
  ); // [R2] [R10] [R14]

  // Integral state; cleared in P-only mode so PI resumes without a kick
  always_ff @(posedge mclk)
  begin
    if (rst || !en_q)
    begin
      integ_q <= '0;
    end
    else if (tick)
    begin
      integ_q <= p_only ? '0 : integ_next; // [R5] [R6]
    end
  end

  // Speed feed-forward: torque for model acceleration scaled by ff gain
  logic signed [W+16:0] acc_ff;
  logic signed [W+17:0] tsum;
  logic sat;
  localparam logic signed [W+17:0] TMAX = (W+18)'({1'b0, {(W-1){1'b1}}});
  always_comb
  begin
    acc_ff = spd_ff_q ? (W+17)'((model_step * signed'({1'b0, ffg_q})) >>> 8) : '0; // [R13]
    tsum = (W+18)'(pi_torque) + (W+18)'(acc_ff);
    sat = (tsum > TMAX) || (tsum < -TMAX);
  end

  logic sat_q;
  always_ff @(posedge mclk)
  begin
    if (rst || !en_q)
    begin
      torque_cmd <= '0;
      sat_q <= 1'b0;
    end
    else if (tick)
    begin
      // Clamp keeps the torque command inside the output width
      torque_cmd <= sat ? (tsum[W+17] ? W'(-TMAX) : W'(TMAX)) : W'(tsum); // [R11] [R13]
      sat_q <= sat;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sample_valid <= 1'b0;
    end
    else
    begin
      sample_valid <= tick && en_q;
    end
  end

  // ----------------------------------------------------------------------
  // Read port: data valid only the cycle after the strobe
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst || !rd)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      case (addr)
        speed_loop_pkg::REG_KP: rdata_q <= {16'h0000, kp_q};
        speed_loop_pkg::REG_TI: rdata_q <= {16'h0000, ti_q};
        speed_loop_pkg::REG_CTRL: rdata_q <= {26'h0, en_q, pos_mode_q, spd_ff_q, pos_ff_q, vis_q};
        speed_loop_pkg::REG_JL: rdata_q <= {16'h0000, jl_q};
        speed_loop_pkg::REG_FF_GAIN: rdata_q <= {16'h0000, ffg_q};
        speed_loop_pkg::REG_STATUS: rdata_q <= {28'h0, sat_q, range_err_q, !unlocked, p_only};
        speed_loop_pkg::REG_TORQUE: rdata_q <= 32'(torque_cmd);
        speed_loop_pkg::REG_INTEG: rdata_q <= 32'(integ_q >>> 16);
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign rdata = rdata_q;

endmodule : speed_loop_pi_controller

// File: hdl/speed_loop_pkg.sv
/*
  Constants for the speed-loop PI controller: parameter ranges, reset values,
  fixed-point scaling and register map of the plain register port.
  Assumes a 100 MHz mclk and a synchronous, active-high reset.
*/
package speed_loop_pkg;

  // ----------------------------------------------------------------------
  // Clock and sample period
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SAMPLE_US = 100;
  localparam int unsigned SAMPLE_CYCLES = CLK_HZ / 1_000_000 * SAMPLE_US;

  // ----------------------------------------------------------------------
  // Setting ranges and reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] KP_MAX_PCT = 16'h03e8;       // 1000 %
  localparam logic [15:0] KP_INIT_SMALL_PCT = 16'h0064; // 100 %
  localparam logic [15:0] KP_INIT_LARGE_PCT = 16'h000f; // 15 %
  localparam logic [15:0] TI_MAX_MS = 16'h4e20;        // 20 s
  localparam logic [15:0] TI_INIT_SMALL_MS = 16'h00c8;  // 0.2 s
  localparam logic [15:0] TI_INIT_LARGE_MS = 16'h014d;  // 0.333 s
  localparam logic [15:0] JL_INIT = 16'h0100;          // 1.0 in Q8
  localparam int unsigned RESP_RAD_S_AT_100 = 200;     // 100 % gain = 200 rad/s

  // ----------------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------------
  localparam logic [3:0] REG_KP = 4'h0;
  localparam logic [3:0] REG_TI = 4'h1;
  localparam logic [3:0] REG_CTRL = 4'h2;
  localparam logic [3:0] REG_JL = 4'h3;
  localparam logic [3:0] REG_FF_GAIN = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_TORQUE = 4'h6;
  localparam logic [3:0] REG_INTEG = 4'h7;

  // CTRL fields
  localparam int unsigned CTRL_VIS_LO = 0; // visibility setting, 2 bits
  localparam int unsigned CTRL_POS_FF = 2;
  localparam int unsigned CTRL_SPD_FF = 3;
  localparam int unsigned CTRL_POS_MODE = 4;
  localparam int unsigned CTRL_ENABLE = 5;

  // STATUS fields
  localparam int unsigned STAT_P_ONLY = 0;
  localparam int unsigned STAT_LOCKED = 1;
  localparam int unsigned STAT_RANGE_ERR = 2;
  localparam int unsigned STAT_SAT = 3;

endpackage : speed_loop_pkg

// File: tb/motor_load_model.sv
/*
  Motor and load seen by the speed loop: speed integrates torque.
  Assumes torque is valid whenever the sample pulse is high.
*/
`timescale 1ns/10ps
module motor_load_model #(
  parameter int W = 24,
  parameter int LAG = 6
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic signed [W-1:0] torque_cmd,
  input wire logic sample_valid,
  output logic signed [W-1:0] speed_fb
);
  // Larger LAG means a heavier load that answers slowly
  always_ff @(posedge mclk)
  begin
    if (rst)
      speed_fb <= '0;
    else if (sample_valid)
      speed_fb <= speed_fb + (torque_cmd >>> LAG);
  end
endmodule : motor_load_model

// File: tb/speed_loop_pi_controller_tb_top.sv
/*
  Self-checking bench for the speed-loop controller and its load.
  Assumes the checker binds itself; small-unit reset values.
*/
`timescale 1ns/10ps
module speed_loop_pi_controller_tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic p_pi_select_input = 1'b0;
  logic signed [23:0] speed_cmd = 24'h0;
  logic signed [23:0] pos_err = 24'h0;
  logic signed [23:0] speed_fb;
  logic signed [23:0] torque_cmd;
  logic sample_valid;
  logic [31:0] exp_q[$];
  logic [31:0] mask_q[$];
  logic rd_d1 = 1'b0;
  logic [31:0] kv[3];
  logic [31:0] tv[3];
  int n_mismatch = 0;
  int checks = 0;

  always #5 mclk = ~mclk;

  speed_loop_pi_controller #(.W(24), .LARGE_UNIT(1'b0)) DUT (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .p_pi_select_input(p_pi_select_input), .speed_cmd(speed_cmd),
    .pos_err(pos_err), .speed_fb(speed_fb), .torque_cmd(torque_cmd), .sample_valid(sample_valid));
  motor_load_model #(.W(24), .LAG(6)) load (.mclk(mclk), .rst(rst), .torque_cmd(torque_cmd),
    .sample_valid(sample_valid), .speed_fb(speed_fb));

  task automatic cmp(input logic [31:0] got, input logic [31:0] e);
    checks++;
    if (got !== e)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, e);
    end
  endtask : cmp

  // Read data stands one cycle only, so take it at that edge
  always @(posedge mclk)
  begin
    if (rd_d1)
      cmp(rdata & mask_q.pop_front(), exp_q.pop_front());
    rd_d1 <= rd;
  end

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge mclk);
    mask_q.push_back(m);
    exp_q.push_back(e & m);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
  endtask : rd_reg

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  // Bounded wait for the next n sample pulses
  task automatic wait_tick(input int n);
    int i;
    repeat (n)
    begin
      @(posedge mclk);
      for (i = 0; i < 25000 && sample_valid !== 1'b1; i++)
        @(posedge mclk);
      if (i == 25000)
      begin
        n_mismatch++;
        end_sim();
      end
    end
    @(posedge mclk);
  endtask : wait_tick

  initial
  begin
    kv[0] = $urandom(32'h1fda7e95);
    kv = '{32'h0, 32'h3e8, $urandom_range(999)};
    tv = '{32'h0, 32'h4e20, $urandom_range(19999)};
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(4'h0, 32'hffff, 32'h64);
    rd_reg(4'h1, 32'hffff, 32'hc8);
    rd_reg(4'h9, 32'hffffffff, 32'h0);
    $display("test reset_values done");
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(4'h0, kv[i]);
      rd_reg(4'h0, 32'hffff, kv[i]);
      wr_reg(4'h1, tv[i]);
      rd_reg(4'h1, 32'hffff, tv[i]);
    end
    wr_reg(4'h0, 32'h3e9);
    rd_reg(4'h0, 32'hffff, kv[2]);
    wr_reg(4'h1, 32'h4e21);
    rd_reg(4'h1, 32'hffff, tv[2]);
    rd_reg(4'h5, 32'h4, 32'h4);
    wr_reg(4'h5, 32'h4);
    rd_reg(4'h5, 32'h4, 32'h0);
    wr_reg(4'h0, 32'h3e9);
    rd_reg(4'h5, 32'h4, 32'h4);
    wr_reg(4'h2, $urandom_range(3, 1));
    wr_reg(4'h0, 32'h7);
    wr_reg(4'h1, 32'h7);
    rd_reg(4'h0, 32'hffff, kv[2]);
    rd_reg(4'h1, 32'hffff, tv[2]);
    $display("test settings done");
    // The select pin stands for a terminal assigned function code 44
    p_pi_select_input <= 1'b1;
    wr_reg(4'h2, 32'h0);
    repeat (4) @(posedge mclk);
    rd_reg(4'h5, 32'h1, 32'h1);
    wr_reg(4'h2, 32'h10);
    rd_reg(4'h5, 32'h1, 32'h0);
    p_pi_select_input <= 1'b0;
    wr_reg(4'h2, 32'h0);
    repeat (4) @(posedge mclk);
    rd_reg(4'h5, 32'h1, 32'h0);
    $display("test select done");
    wr_reg(4'h0, 32'h64);
    wr_reg(4'h1, 32'hc8);
    speed_cmd <= 24'(1000 + $urandom_range(3000));
    wr_reg(4'h2, 32'h20);
    // First sample after enable still sees a zero model, so torque follows one sample later
    wait_tick(2);
    cmp(32'(torque_cmd > 24'sh0), 32'h1);
    speed_cmd <= -24'sd4000;
    wait_tick(3);
    cmp(32'(torque_cmd < 24'sh0), 32'h1);
    p_pi_select_input <= 1'b1;
    wait_tick(2);
    rd_reg(4'h7, 32'hffffffff, 32'h0);
    // Let the last read data reach the compare process before closing
    repeat (2) @(posedge mclk);
    if (exp_q.size() != 0)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, exp_q.size(), 0);
    end
    $display("test loop done");
    end_sim();
  end
endmodule : speed_loop_pi_controller_tb_top

// File: tb/speed_loop_props.sv
/*
  Port checker for the speed-loop controller.
  Assumes binding by the statement at the foot; rst is synchronous on mclk.
*/
`timescale 1ns/10ps
module speed_loop_props #(
  parameter int W = 24,
  parameter bit LARGE_UNIT = 1'b0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic p_pi_select_input,
  input wire logic signed [W-1:0] speed_cmd,
  input wire logic signed [W-1:0] pos_err,
  input wire logic signed [W-1:0] speed_fb,
  input wire logic signed [W-1:0] torque_cmd,
  input wire logic sample_valid
);
  logic [1:0] vis_q;
  logic pos_q;
  logic [15:0] kp_q;
  logic [15:0] ti_q;

  // Shadow of accepted settings; refused writes must leave it alone
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      vis_q <= 2'h0;
      pos_q <= 1'b0;
      kp_q <= LARGE_UNIT ? speed_loop_pkg::KP_INIT_LARGE_PCT : speed_loop_pkg::KP_INIT_SMALL_PCT;
      ti_q <= LARGE_UNIT ? speed_loop_pkg::TI_INIT_LARGE_MS : speed_loop_pkg::TI_INIT_SMALL_MS;
    end
    else if (wr)
    begin
      if (addr == speed_loop_pkg::REG_CTRL)
      begin
        vis_q <= wdata[1:0];
        pos_q <= wdata[speed_loop_pkg::CTRL_POS_MODE];
      end
      // Whole word is range-checked: upper bits set means out of range
      if (addr == speed_loop_pkg::REG_KP && vis_q == 2'h0 && wdata <= {16'h0000, speed_loop_pkg::KP_MAX_PCT})
        kp_q <= wdata[15:0];
      if (addr == speed_loop_pkg::REG_TI && vis_q == 2'h0 && wdata <= {16'h0000, speed_loop_pkg::TI_MAX_MS})
        ti_q <= wdata[15:0];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence kp_bad_wr;
    wr && addr == speed_loop_pkg::REG_KP && wdata > {16'h0000, speed_loop_pkg::KP_MAX_PCT};
  endsequence
  sequence stat_rd;
    rd && addr == speed_loop_pkg::REG_STATUS;
  endsequence

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  reset_clear_a: assert property (disable iff (1'b0) rst |=> torque_cmd == '0 && !sample_valid && rdata == 32'h0)
    else $error("outputs not cleared by reset");
  rd_idle_a: assert property (!rd |=> rdata == 32'h0)
    else $error("read data outside read cycle");
  valid_pulse_a: assert property (sample_valid |=> !sample_valid [*8])
    else $error("sample pulse too long or too close");
  torque_tick_a: assert property ($changed(torque_cmd) |-> sample_valid)
    else $error("torque changed without sample pulse");
  kp_shadow_a: assert property (rd && addr == speed_loop_pkg::REG_KP |=> rdata[15:0] == $past(kp_q))
    else $error("gain readback wrong");
  ti_shadow_a: assert property (rd && addr == speed_loop_pkg::REG_TI |=> rdata[15:0] == $past(ti_q))
    else $error("integral time readback wrong");
  range_flag_a: assert property (kp_bad_wr ##1 !wr ##1 stat_rd |=> rdata[speed_loop_pkg::STAT_RANGE_ERR])
    else $error("range error not flagged");
  p_only_a: assert property (p_pi_select_input [*4] ##0 (stat_rd and !pos_q) |=> rdata[0])
    else $error("select high but not proportional only");
  pi_mode_a: assert property ((!p_pi_select_input) [*4] ##0 stat_rd |=> !rdata[0])
    else $error("select low but proportional only");
  pos_ignore_a: assert property (rd && addr == speed_loop_pkg::REG_STATUS && pos_q |=> !rdata[0])
    else $error("position mode did not keep integral");
endmodule : speed_loop_props

bind speed_loop_pi_controller speed_loop_props #(.W(W), .LARGE_UNIT(LARGE_UNIT)) u_props (.mclk(mclk),
  .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .p_pi_select_input(p_pi_select_input),
  .speed_cmd(speed_cmd), .pos_err(pos_err), .speed_fb(speed_fb), .torque_cmd(torque_cmd),
  .sample_valid(sample_valid));
